// file: timer_pkg.sv
package timer_pkg;
  // register word addresses (byte offsets over the bus)
  localparam logic [3:0] ADDR_COUNT   = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_IRQ     = 4'h8;
  // control field positions
  localparam int MODE_HI_POS   = 7;
  localparam int MODE_LO_POS   = 6;
  localparam int ENABLE_POS    = 4;
  localparam int EDGE_POS      = 3;
  localparam int PRESCALE_MSB  = 2;
  // irq register field positions
  localparam int IRQ_FLAG_POS  = 0;
  localparam int IRQ_EN_POS    = 1;
  localparam int CLK_SEL_POS   = 2;
  // reset values and the full count
  localparam logic [7:0] CONTROL_RESET = 8'h08;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] COUNT_FULL    = 8'hFF;
  // internal source divider for the slow timebase
  localparam int SYS_DIV4      = 4;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  typedef enum logic [1:0] {
    MODE_NONE  = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_TIMER = 2'b10,
    MODE_PULSE = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    PW_IDLE  = 2'b00,
    PW_COUNT = 2'b01,
    PW_DONE  = 2'b10
  } pw_state_t;

  // control register layout
  typedef struct packed {
    mode_t      mode;
    logic       unused5;
    logic       enable;
    logic       edge_sel;
    logic [2:0] prescale;
  } control_t;

  // avalon request bundle
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } av_req_t;
endpackage : timer_pkg

// file: pin_sync.sv
// two-stage synchroniser with edge detect on the settled copy
module pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // raw pin
  input  wire logic pin_in,
  // synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic prev_reg, prev_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;
endmodule : pin_sync

// file: event_timer.sv
// Chosen here: the Avalon-MM register port and the register offsets.
module event_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // external count pin
  input  wire logic        external_count_pin,
  // events to the core
  output logic             irq_req,
  output logic             wake_req,
  output logic             overflow_pulse
);
  timer_pkg::control_t ctrl_reg, ctrl_next;
  logic [7:0]  count_reg, count_next;
  logic [7:0]  preload_reg, preload_next;
  logic [6:0]  presc_reg, presc_next;
  logic [1:0]  div4_reg, div4_next;
  logic        flag_reg, flag_next;
  logic        irq_en_reg, irq_en_next;
  logic        slow_sel_reg, slow_sel_next;
  logic        pw_active_reg, pw_active_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        ack_reg, ack_next;
  logic        irq_reg, irq_next;
  logic        wake_reg, wake_next;
  logic        ovf_reg, ovf_next;
  logic        pin_level, pin_rise, pin_fall;
  logic        src_tick, presc_fall, tick, ovf, pw_end, pw_start;
  logic        wr_hit, rd_hit;
  timer_pkg::av_req_t req;

  pin_sync i_pin_sync (
    .clk    (clk),
    .reset  (reset),
    .pin_in (external_count_pin),
    .level  (pin_level),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  assign req    = '{address: address, read: read, write: write, writedata: writedata};
  // one wait cycle per access; read data is captured on the first edge so it
  // stands at the accepting edge, while a write lands only on the accepting
  // edge, the one at which the master sees waitrequest low
  assign wr_hit = req.write & ack_reg;
  assign rd_hit = req.read & ~ack_reg;

  // internal timebase and prescaler
  always_comb begin
    div4_next = div4_reg + 2'h1;
    src_tick  = slow_sel_reg ? (div4_reg == timer_pkg::DIV4_LAST) : 1'b1;
    // seven bits suffice: ratio 128 watches bit 6 only
    presc_next = src_tick ? presc_reg + 7'h01 : presc_reg;
    // falling edge of selected divider bit; ratio 1 is every source tick
    if (ctrl_reg.prescale == 3'h0) begin
      presc_fall = src_tick;
    end else begin
      presc_fall = src_tick & presc_reg[ctrl_reg.prescale - 3'h1]
                   & ~presc_next[ctrl_reg.prescale - 3'h1];
    end
  end

  // tick qualification per mode
  always_comb begin
    pw_active_next = pw_active_reg;
    pw_start = 1'b0;
    pw_end   = 1'b0;
    tick     = 1'b0;
    case (ctrl_reg.mode)
      timer_pkg::MODE_EVENT: begin
        // pin edge, undivided, no clock gating
        tick = ctrl_reg.enable & (ctrl_reg.edge_sel ? pin_fall : pin_rise);
      end
      timer_pkg::MODE_TIMER: begin
        tick = ctrl_reg.enable & presc_fall;
      end
      timer_pkg::MODE_PULSE: begin
        // start edge opens the window, opposite edge closes it
        pw_start = ctrl_reg.enable & ~pw_active_reg
                   & (ctrl_reg.edge_sel ? pin_rise : pin_fall);
        pw_end   = ctrl_reg.enable & pw_active_reg
                   & (ctrl_reg.edge_sel ? pin_fall : pin_rise);
        if (pw_start) pw_active_next = 1'b1;
        if (pw_end) pw_active_next = 1'b0;
        tick = ctrl_reg.enable & pw_active_reg & ~pw_end & presc_fall;
      end
      default: tick = 1'b0;
    endcase
    if (!ctrl_reg.enable) pw_active_next = 1'b0;
  end

  assign ovf = tick & (count_reg == timer_pkg::COUNT_FULL);

  // counter, preload, control and flags
  always_comb begin
    ctrl_next     = ctrl_reg;
    preload_next  = preload_reg;
    irq_en_next   = irq_en_reg;
    slow_sel_next = slow_sel_reg;
    flag_next     = flag_reg;
    count_next = tick ? count_reg + 8'h01 : count_reg;
    if (ovf) count_next = preload_reg;
    if (wr_hit && req.address == timer_pkg::ADDR_COUNT) begin
      preload_next = req.writedata[7:0];
      if (!ctrl_reg.enable) count_next = req.writedata[7:0];
    end
    if (wr_hit && req.address == timer_pkg::ADDR_CONTROL) begin
      ctrl_next = timer_pkg::control_t'(req.writedata[7:0]);
      ctrl_next.unused5 = 1'b0;
    end
    // write one clears; a same-cycle overflow wins
    if (wr_hit && req.address == timer_pkg::ADDR_IRQ) begin
      irq_en_next   = req.writedata[timer_pkg::IRQ_EN_POS];
      slow_sel_next = req.writedata[timer_pkg::CLK_SEL_POS];
      if (req.writedata[timer_pkg::IRQ_FLAG_POS]) flag_next = 1'b0;
    end
    if (ovf) flag_next = 1'b1;
    // capture end drops the enable, after any software write
    if (pw_end) ctrl_next.enable = 1'b0;
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_hit) begin
      case (req.address)
        timer_pkg::ADDR_COUNT:   rdata_next = {24'h00_0000, count_reg};
        timer_pkg::ADDR_CONTROL: rdata_next = {24'h00_0000, ctrl_reg};
        timer_pkg::ADDR_IRQ:     rdata_next = {29'h0000_0000, slow_sel_reg,
                                                irq_en_reg, flag_reg};
        default:                 rdata_next = 32'h0000_0000;
      endcase
    end
    ack_next  = (req.read | req.write) & ~ack_reg;
    // enable masks the interrupt; wake follows the masked request
    irq_next  = flag_next & irq_en_next;
    wake_next = flag_next & irq_en_next;
    ovf_next  = ovf;
  end

  // preload is left unreset; its contents are undefined until written
  always_ff @(posedge clk) begin
    preload_reg <= preload_next;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg      <= timer_pkg::control_t'(timer_pkg::CONTROL_RESET);
      count_reg     <= timer_pkg::COUNT_RESET;
      presc_reg     <= 7'h00;
      div4_reg      <= 2'h0;
      flag_reg      <= 1'b0;
      irq_en_reg    <= 1'b0;
      slow_sel_reg  <= 1'b0;
      pw_active_reg <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
      ack_reg       <= 1'b0;
      irq_reg       <= 1'b0;
      wake_reg      <= 1'b0;
      ovf_reg       <= 1'b0;
    end else begin
      ctrl_reg      <= ctrl_next;
      count_reg     <= count_next;
      presc_reg     <= presc_next;
      div4_reg      <= div4_next;
      flag_reg      <= flag_next;
      irq_en_reg    <= irq_en_next;
      slow_sel_reg  <= slow_sel_next;
      pw_active_reg <= pw_active_next;
      rdata_reg     <= rdata_next;
      ack_reg       <= ack_next;
      irq_reg       <= irq_next;
      wake_reg      <= wake_next;
      ovf_reg       <= ovf_next;
    end
  end

  // waitrequest is low only in the second cycle of a request; it is high while idle and in the first cycle
  logic wait_reg, wait_next;
  always_comb begin
    wait_next = ~ack_next;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= wait_next;
    end
  end

  assign readdata       = rdata_reg;
  // every output comes straight from its flop, so no glitch reaches the bus
  assign waitrequest    = wait_reg;
  assign irq_req        = irq_reg;
  assign wake_req       = wake_reg;
  assign overflow_pulse = ovf_reg;

  // assertions
  sequence full_tick_s;
    tick && count_reg == timer_pkg::COUNT_FULL;
  endsequence

  overflow_reload_a: assert property (@(posedge clk) disable iff (reset)
    full_tick_s |=> count_reg == $past(preload_reg)) else $error("no reload on overflow");
  overflow_flag_a: assert property (@(posedge clk) disable iff (reset)
    ovf |=> flag_reg && overflow_pulse) else $error("overflow flag or pulse missing");
  disabled_hold_a: assert property (@(posedge clk) disable iff (reset)
    !ctrl_reg.enable && !wr_hit |=> $stable(count_reg)) else $error("counter moved while off");
  count_step_a: assert property (@(posedge clk) disable iff (reset)
    tick && count_reg != timer_pkg::COUNT_FULL && !wr_hit |=> count_reg == $past(count_reg) + 8'h01)
    else $error("counter step not one");
  no_mode_a: assert property (@(posedge clk) disable iff (reset)
    ctrl_reg.mode == timer_pkg::MODE_NONE |-> !tick) else $error("counted with no mode");
  event_edge_a: assert property (@(posedge clk) disable iff (reset)
    ctrl_reg.mode == timer_pkg::MODE_EVENT && ctrl_reg.enable && pin_rise && !ctrl_reg.edge_sel
    |-> tick) else $error("rising edge not counted");
  capture_end_a: assert property (@(posedge clk) disable iff (reset)
    pw_end |=> !ctrl_reg.enable) else $error("enable kept after capture");
  direct_load_a: assert property (@(posedge clk) disable iff (reset)
    wr_hit && req.address == timer_pkg::ADDR_COUNT && !ctrl_reg.enable
    |=> count_reg == $past(req.writedata[7:0])) else $error("direct load missed");
  irq_mask_a: assert property (@(posedge clk) disable iff (reset)
    !irq_en_reg ##1 !irq_en_reg |-> !irq_req) else $error("masked interrupt raised");

  // capture window opens on the start edge picked by the edge bit
  sequence capture_open_s;
    ctrl_reg.mode == timer_pkg::MODE_PULSE && ctrl_reg.enable && !pw_active_reg
    && (ctrl_reg.edge_sel ? pin_rise : pin_fall);
  endsequence

  // capture unit with its enable already dropped
  sequence capture_off_s;
    ctrl_reg.mode == timer_pkg::MODE_PULSE && !ctrl_reg.enable;
  endsequence

  capture_start_a: assert property (@(posedge clk) disable iff (reset)
    capture_open_s |=> pw_active_reg) else $error("capture window not opened");
  // no window while the enable is clear
  capture_idle_a: assert property (@(posedge clk) disable iff (reset)
    capture_off_s |=> !pw_active_reg) else $error("capture ran while off");
  event_fall_a: assert property (@(posedge clk) disable iff (reset)
    ctrl_reg.mode == timer_pkg::MODE_EVENT && ctrl_reg.enable && pin_fall && ctrl_reg.edge_sel
    |-> tick) else $error("falling edge not counted");
  // enabled write leaves the live count alone
  deferred_load_a: assert property (@(posedge clk) disable iff (reset)
    wr_hit && req.address == timer_pkg::ADDR_COUNT && ctrl_reg.enable && !tick
    |=> count_reg == $past(count_reg) && preload_reg == $past(req.writedata[7:0]))
    else $error("enabled write reached counter");
  // count read returns the counter as it stood in the request's first cycle, captured on the first edge
  read_data_a: assert property (@(posedge clk) disable iff (reset)
    rd_hit && req.address == timer_pkg::ADDR_COUNT
    |=> !waitrequest && readdata == {24'h00_0000, $past(count_reg)})
    else $error("count read wrong");
  // an unmasked request is also a wake source
  wake_source_a: assert property (@(posedge clk) disable iff (reset)
    flag_reg && irq_en_reg |-> wake_req && irq_req) else $error("wake not raised");
endmodule : event_timer

// file: count_pin_model.sv
// far-side source for the external count pin
module count_pin_model (
  // clock
  input  wire logic clk,
  // driven pin
  output logic      pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // the pin idles low until a scenario picks another level
  initial begin
    pin = 1'b0;
  end

  // drive one level for n cycles, changed just after an edge
  // levels last well beyond the synchroniser depth so no edge is lost
  task hold(input logic v, input int n);
    @(posedge clk);
    pin <= v;
    repeat (n - 1) @(posedge clk);
  endtask : hold

  // n full pulses away from the idle level and back
  task pulses(input logic idle, input int n);
    repeat (n) begin
      hold(~idle, 5);
      hold(idle, 5);
    end
  endtask : pulses
endmodule : count_pin_model

// file: test_event_timer.sv
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %0t got %h exp %h", $time, got, exp); end end

module test_event_timer;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        reset;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        pin;
  logic        irq_req;
  logic        wake_req;
  logic        overflow_pulse;
  logic [31:0] seed;
  logic [7:0]  d;
  logic [7:0]  p;
  int          bad_count;
  int          samples_checked;
  int          ovf_seen;
  int          n;
  int          w;
  int          e;

  event_timer i_event_timer (.clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .external_count_pin(pin), .irq_req(irq_req), .wake_req(wake_req),
    .overflow_pulse(overflow_pulse));
  count_pin_model i_count_pin_model (.clk(clk), .pin(pin));

  // xorshift source, fixed start so every run repeats
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // expected timer ticks over a window for a prescale code and source
  function automatic int ticks_exp(input int cycles, input int code, input bit slow);
    return cycles / ((1 << code) * (slow ? 4 : 1));
  endfunction : ticks_exp

  // bus write: hold the request until waitrequest is seen low
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    address   <= a;
    write     <= 1'b1;
    writedata <= {24'h0000_00, v};
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : wr

  // bus read: data taken at the accepting edge
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    address <= a;
    read    <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    v = readdata[7:0];
    read <= 1'b0;
  endtask : rd

  task end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // count one-cycle overflow pulses
  always @(posedge clk) begin
    if (overflow_pulse === 1'b1) ovf_seen++;
  end

  // watchdog sized well above the whole sequence
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    {address, read, write, writedata} = '0;
    reset = 1'b1;
    seed  = 32'h0001_34C1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(timer_pkg::ADDR_CONTROL, d); `CHK(d, timer_pkg::CONTROL_RESET) // reset
    rd(timer_pkg::ADDR_COUNT, d); `CHK(d, timer_pkg::COUNT_RESET) // reset
    rd(4'hC, d); `CHK(d, 8'h00) // unmapped
    // event mode, bit 5 written high, prescale 7 must not divide pin edges
    wr(timer_pkg::ADDR_CONTROL, 8'h67);
    rd(timer_pkg::ADDR_CONTROL, d); `CHK(d, 8'h47) // layout
    p = 8'(xs() & 32'h0000_007F);
    wr(timer_pkg::ADDR_COUNT, p);
    rd(timer_pkg::ADDR_COUNT, d); `CHK(d, p) // direct load
    wr(timer_pkg::ADDR_CONTROL, 8'h57);
    n = 1 + xs() % 8;
    i_count_pin_model.pulses(1'b0, n);
    rd(timer_pkg::ADDR_COUNT, d); `CHK(d, p + n[7:0])
    // falling-edge select: a rise alone must not count
    wr(timer_pkg::ADDR_CONTROL, 8'h5F);
    i_count_pin_model.hold(1'b1, 6);
    rd(timer_pkg::ADDR_COUNT, d); `CHK(d, p + n[7:0]) // rise ignored
    i_count_pin_model.hold(1'b0, 6);
    rd(timer_pkg::ADDR_COUNT, d); `CHK(d, p + n[7:0] + 8'h01) // fall counted
    // halt, load near full, enable, then a preload write that must wait
    wr(timer_pkg::ADDR_CONTROL, 8'h4F);
    i_count_pin_model.pulses(1'b0, 2);
    rd(timer_pkg::ADDR_COUNT, d); `CHK(d, p + n[7:0] + 8'h01) // halted
    wr(timer_pkg::ADDR_COUNT, 8'hFE);
    wr(timer_pkg::ADDR_CONTROL, 8'h5F);
    wr(timer_pkg::ADDR_COUNT, 8'h80);
    rd(timer_pkg::ADDR_COUNT, d); `CHK(d, 8'hFE) // deferred
    ovf_seen = 0;
    i_count_pin_model.pulses(1'b0, 2);
    rd(timer_pkg::ADDR_COUNT, d); `CHK(d, 8'h80) // reload
    `CHK(ovf_seen, 1) // pulse
    `CHK(irq_req, 1'b0) // masked
    rd(timer_pkg::ADDR_IRQ, d); `CHK(d[0], 1'b1) // sticky
    wr(timer_pkg::ADDR_IRQ, 8'h02);
    repeat (2) @(posedge clk);
    `CHK(irq_req, 1'b1) // request
    `CHK(wake_req, 1'b1) // wake
    wr(timer_pkg::ADDR_IRQ, 8'h03);
    repeat (2) @(posedge clk);
    `CHK(irq_req, 1'b0) // acknowledge
    // timer mode over every prescale code, then one slow-source run
    for (int c = 0; c < 9; c++) begin
      e = (c < 8) ? c : xs() % 4;
      wr(timer_pkg::ADDR_IRQ, (c < 8) ? 8'h00 : 8'h04);
      wr(timer_pkg::ADDR_CONTROL, 8'h80 | e[7:0]);
      wr(timer_pkg::ADDR_COUNT, 8'h00);
      w = 20 * (1 << e) * ((c < 8) ? 1 : 4);
      wr(timer_pkg::ADDR_CONTROL, 8'h90 | e[7:0]);
      repeat (w) @(posedge clk);
      wr(timer_pkg::ADDR_CONTROL, 8'h80 | e[7:0]);
      rd(timer_pkg::ADDR_COUNT, d);
      // enable and disable writes each land on their accepting edge: w + 3 cycles
      n = ticks_exp(w + 3, e, c == 8);
      `CHK(int'(d) >= n - 1 && int'(d) <= n + 2, 1'b1)
    end
    // capture, edge 0: low pulse of 20 cycles on a high idle pin
    wr(timer_pkg::ADDR_IRQ, 8'h00);
    wr(timer_pkg::ADDR_CONTROL, 8'hC0);
    i_count_pin_model.hold(1'b1, 6);
    wr(timer_pkg::ADDR_COUNT, 8'h00);
    wr(timer_pkg::ADDR_CONTROL, 8'hD0);
    i_count_pin_model.hold(1'b0, 20);
    i_count_pin_model.hold(1'b1, 8);
    rd(timer_pkg::ADDR_CONTROL, d); `CHK(d, 8'hC0) // self clear
    rd(timer_pkg::ADDR_COUNT, p);
    `CHK(int'(p) >= 18 && int'(p) <= 22, 1'b1) // width
    i_count_pin_model.pulses(1'b1, 2);
    rd(timer_pkg::ADDR_COUNT, d); `CHK(d, p) // ignored
    // capture, edge 1: high pulse of 12 cycles on a low idle pin
    i_count_pin_model.hold(1'b0, 6);
    wr(timer_pkg::ADDR_COUNT, 8'h00);
    wr(timer_pkg::ADDR_CONTROL, 8'hD8);
    i_count_pin_model.hold(1'b1, 12);
    i_count_pin_model.hold(1'b0, 8);
    rd(timer_pkg::ADDR_CONTROL, d); `CHK(d, 8'hC8) // self clear
    rd(timer_pkg::ADDR_COUNT, d);
    `CHK(int'(d) >= 10 && int'(d) <= 14, 1'b1) // width
    end_of_test();
  end
endmodule : test_event_timer
